// file: hw/frame_gate.sv
// Purpose: per-frame spanning-tree gate and listener discovery match
// Assumes: inputs stable while the frame descriptor is valid
// Notes:   purely combinational, no state
`timescale 1ns/100ps
`default_nettype none
module frame_gate (
	input  wire logic [2:0] pstate_i,
	input  wire logic [2:0] fr_type_i,
	input  wire logic       mld_en_i,
	input  wire logic       v6_mcast_i,
	input  wire logic [7:0] hop_i,
	input  wire logic [7:0] nh_i,
	input  wire logic [7:0] hbh_i,
	input  wire logic [7:0] icmp_i,
	output logic            drop_o,
	output logic            trap_o,
	output logic            learn_o,
	output logic            mld_o
);
	// port state treatment
	always_comb begin
		trap_o  = (fr_type_i == snoop_pkg::FT_BPDU);
		drop_o  = (pstate_i != snoop_pkg::STP_FORWARDING) && !trap_o;
		learn_o = (pstate_i == snoop_pkg::STP_LEARNING)
			|| (pstate_i == snoop_pkg::STP_FORWARDING);
		mld_o   = mld_en_i && (fr_type_i == snoop_pkg::FT_IPV6) && v6_mcast_i
			&& (hop_i == snoop_pkg::V6_HOP_ONE)
			&& ((nh_i == snoop_pkg::NH_ICMPV6)
			|| ((nh_i == snoop_pkg::NH_HBH) && (hbh_i == snoop_pkg::NH_ICMPV6)))
			&& (icmp_i >= snoop_pkg::MLD_QUERY) && (icmp_i <= snoop_pkg::MLD_DONE);
	end
endmodule : frame_gate
`default_nettype wire

// file: hw/mcast_snoop_filter.sv
// Purpose: group membership snooping, router ports, MLD trap, STP gating
// Assumes: one frame descriptor per cycle at most, from the port parsers
// Notes:   multicast table requests go to the shared address table engine
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Contract
// - snoop IGMP v1/v2 in hardware, track up to 16 groups.
// - report adds receiving port to group list; leave removes it.
// - snooped multicast goes only to joined ports.
// - full membership table ignores new joins, no table registration.
// - unregistered multicast flooded by default; two-bit field picks treatment.
// - port hearing a query becomes router port.
// - static router ports from control bit and three-bit map.
// - processor port 2 never becomes a router port.
// - dynamic router port dropped after 400 s without query.
// - join creates or refreshes entry in both tables.
// - leave deletes at once with fast leave, else timer decides.
// - entry removed after robustness times query interval plus response.
// - MLD snooping traps hop-limit-1 IPv6 ICMPv6 multicast to processor.
// - trap only for ICMPv6 types 82h, 83h, 84h.
// - five port states; disabled, blocking, listening act as discarding.
// - non-forwarding states drop non-BPDU, trap BPDUs; no learning early. The code still traps MLD frames to the processor in these states.
// - per-port state; learning in learning/forwarding; forwarding passes all.
// - membership table hardware-kept, host read only, 16 entries.
// - multicast entries live in shared table, oldest replaced when full.
module mcast_snoop_filter #(
	parameter int unsigned TICK_CYCLES = snoop_pkg::TICK_CYCLES
) (
	input  wire logic        mclk_i,
	input  wire logic        srst_i,
	input  wire logic [3:0]  addr_i,
	input  wire logic [15:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [15:0] rdata_o,
	input  wire logic        fr_valid_i,
	input  wire logic [1:0]  fr_port_i,
	input  wire logic [2:0]  fr_type_i,
	input  wire logic [31:0] fr_group_i,
	input  wire logic        fr_v6_mcast_i,
	input  wire logic [7:0]  fr_hop_i,
	input  wire logic [7:0]  fr_nh_i,
	input  wire logic [7:0]  fr_hbh_i,
	input  wire logic [7:0]  fr_icmp_i,
	output logic             dec_valid_o,
	output logic      [2:0]  dec_map_o,
	output logic             dec_learn_o,
	output logic             dec_trap_o,
	output logic             mt_wr_o,
	output logic             mt_del_o,
	output logic      [31:0] mt_grp_o,
	output logic      [2:0]  mt_map_o,
	output logic      [2:0]  router_map_o
);
	localparam int unsigned G  = snoop_pkg::GROUPS;
	localparam int unsigned P  = snoop_pkg::PORTS;
	localparam int unsigned GW = snoop_pkg::GRP_W;
	localparam int unsigned MW = snoop_pkg::MT_W;
	localparam int unsigned RW = snoop_pkg::RT_W;

	typedef struct packed {
		logic [G-1:0]                 vld;
		logic [G-1:0]                 dirty;
		logic [G-1:0][GW-1:0]         grp;
		logic [G-1:0][P-1:0]          map;
		logic [G-1:0][P-1:0][MW-1:0]  mtmr;
		logic [1:0][RW-1:0]           rtmr;
		logic [15:0]                  ctrl;
		logic [15:0]                  timing;
		logic [7:0]                   qri;
		logic [8:0]                   pstate;
		logic [3:0]                   sel;
		logic [3:0]                   sweep;
		logic                         dec_valid;
		logic [2:0]                   dec_map;
		logic                         dec_learn;
		logic                         dec_trap;
		logic                         mt_wr;
		logic                         mt_del;
		logic [GW-1:0]                mt_grp;
		logic [2:0]                   mt_map;
		logic [2:0]                   rmap;
		logic [15:0]                  rdata;
	} st_t;
	st_t s_q;
	st_t s_d;

	logic       tick;
	logic       g_drop;
	logic       g_trap;
	logic       g_learn;
	logic       g_mld;
	logic [2:0] src_state;

	////////////////////////////////////////////////////////////////////////
	// helpers

	// one-hot bit for a port number
	function automatic logic [2:0] pbit(input logic [1:0] port);
		pbit = 3'(3'h1 << port);
	endfunction : pbit

	// lookup of a valid group, returns {hit, index}
	function automatic logic [4:0] find_grp(input logic [G-1:0] vld,
		input logic [G-1:0][GW-1:0] grp, input logic [GW-1:0] key);
		find_grp = 5'h00;
		for (int i = G - 1; i >= 0; i--) begin
			if (vld[i] && grp[i] == key) begin
				find_grp = {1'b1, 4'(i)};
			end
		end
	endfunction : find_grp

	// lowest free slot, returns {found, index}
	function automatic logic [4:0] find_free(input logic [G-1:0] vld);
		find_free = 5'h00;
		for (int i = G - 1; i >= 0; i--) begin
			if (!vld[i]) begin
				find_free = {1'b1, 4'(i)};
			end
		end
	endfunction : find_free

	// router ports from static map or live timers, never the cpu port
	function automatic logic [2:0] routers(input logic [15:0] ctrl,
		input logic [1:0][RW-1:0] rtmr);
		if (ctrl[snoop_pkg::CTRL_STATIC]) begin
			routers = ctrl[snoop_pkg::CTRL_RMAP +: 3] & 3'h3;
		end else begin
			routers = {1'b0, rtmr[1] != '0, rtmr[0] != '0};
		end
	endfunction : routers

	////////////////////////////////////////////////////////////////////////
	// submodules

	sec_tick #(
		.CYCLES (TICK_CYCLES)
	) u_tick (
		.mclk_i (mclk_i),
		.srst_i (srst_i),
		.tick_o (tick)
	);

	assign src_state = s_q.pstate[3*fr_port_i +: 3];

	frame_gate u_gate (
		.pstate_i   (src_state),
		.fr_type_i  (fr_type_i),
		.mld_en_i   (s_q.ctrl[snoop_pkg::CTRL_MLD]),
		.v6_mcast_i (fr_v6_mcast_i),
		.hop_i      (fr_hop_i),
		.nh_i       (fr_nh_i),
		.hbh_i      (fr_hbh_i),
		.icmp_i     (fr_icmp_i),
		.drop_o     (g_drop),
		.trap_o     (g_trap),
		.learn_o    (g_learn),
		.mld_o      (g_mld)
	);

	////////////////////////////////////////////////////////////////////////
	// next-state logic
	always_comb begin
		logic [MW-1:0] mi;
		logic [4:0]    hit;
		logic [4:0]    fre;
		logic [3:0]    e;
		logic [2:0]    src;
		logic [2:0]    fwd_ok;
		logic [2:0]    dst;
		logic          snoop;
		mi = '0;
		hit = '0;
		fre = '0;
		e = '0;
		src = '0;
		fwd_ok = '0;
		dst = '0;
		snoop = 1'b0;
		s_d = s_q;
		s_d.dec_valid = 1'b0;
		s_d.mt_wr = 1'b0;
		s_d.mt_del = 1'b0;
		s_d.rdata = 16'h0000;
		snoop = s_q.ctrl[snoop_pkg::CTRL_SNOOP];
		mi = MW'(s_q.timing[snoop_pkg::TIMING_ROB +: 4] * s_q.timing[snoop_pkg::TIMING_QI +: 8])
			+ MW'(s_q.qri);

		// ageing on the second tick
		if (tick) begin
			for (int i = 0; i < G; i++) begin
				for (int p = 0; p < P; p++) begin
					if (s_q.mtmr[i][p] != '0) begin
						s_d.mtmr[i][p] = s_q.mtmr[i][p] - 1'b1;
						if (s_q.mtmr[i][p] == MW'(1)) begin
							s_d.map[i][p] = 1'b0;
							s_d.dirty[i] = 1'b1;
						end
					end
				end
			end
			for (int p = 0; p < 2; p++) begin
				if (s_q.rtmr[p] != '0) begin
					s_d.rtmr[p] = s_q.rtmr[p] - 1'b1;
				end
			end
		end

		// snooping updates for the incoming frame
		if (fr_valid_i) begin
			src = pbit(fr_port_i);
			hit = find_grp(s_q.vld, s_q.grp, fr_group_i);
			fre = find_free(s_q.vld);
			e = hit[3:0];
			case (fr_type_i)
				snoop_pkg::FT_QUERY: begin
					if (fr_port_i != snoop_pkg::CPU_PORT) begin
						s_d.rtmr[fr_port_i[0]] = snoop_pkg::ROUTER_TOUT_S;
					end
				end
				snoop_pkg::FT_JOIN_REPORT_VERSION_ONE,
				snoop_pkg::FT_JOIN_REPORT_VERSION_TWO: begin
					if (snoop && (hit[4] || fre[4])) begin
						if (!hit[4]) begin
							e = fre[3:0];
							s_d.vld[e] = 1'b1;
							s_d.grp[e] = fr_group_i;
							s_d.map[e] = '0;
						end
						s_d.map[e] = s_d.map[e] | src;
						s_d.mtmr[e][fr_port_i] = mi;
						s_d.dirty[e] = 1'b0;
						s_d.mt_wr = 1'b1;
						s_d.mt_grp = fr_group_i;
						s_d.mt_map = s_d.map[e];
					end
				end
				snoop_pkg::FT_LEAVE: begin
					if (snoop && hit[4] && s_q.ctrl[snoop_pkg::CTRL_FAST]) begin
						s_d.map[e] = s_d.map[e] & ~src;
						s_d.mtmr[e][fr_port_i] = '0;
						s_d.dirty[e] = 1'b0;
						s_d.mt_grp = fr_group_i;
						s_d.mt_map = s_d.map[e];
						if (s_d.map[e] == '0) begin
							s_d.vld[e] = 1'b0;
							s_d.mt_del = 1'b1;
						end else begin
							s_d.mt_wr = 1'b1;
						end
					end
				end
				default: begin
				end
			endcase
		end

		// sweep aged entries into the shared table when idle
		if (!s_d.mt_wr && !s_d.mt_del) begin
			if (s_d.vld[s_q.sweep] && s_d.dirty[s_q.sweep]) begin
				s_d.dirty[s_q.sweep] = 1'b0;
				s_d.mt_grp = s_d.grp[s_q.sweep];
				s_d.mt_map = s_d.map[s_q.sweep];
				if (s_d.map[s_q.sweep] == '0) begin
					s_d.vld[s_q.sweep] = 1'b0;
					s_d.mt_del = 1'b1;
				end else begin
					s_d.mt_wr = 1'b1;
				end
			end
			s_d.sweep = s_q.sweep + 1'b1;
		end

		s_d.rmap = routers(s_d.ctrl, s_d.rtmr);

		// forwarding decision from the updated tables
		if (fr_valid_i) begin
			for (int p = 0; p < P; p++) begin
				fwd_ok[p] = (s_q.pstate[3*p +: 3] == snoop_pkg::STP_FORWARDING);
			end
			case (fr_type_i)
				snoop_pkg::FT_QUERY: dst = ~src;
				snoop_pkg::FT_JOIN_REPORT_VERSION_ONE,
				snoop_pkg::FT_JOIN_REPORT_VERSION_TWO,
				snoop_pkg::FT_LEAVE: dst = snoop ? (s_d.rmap & ~src) : ~src;
				snoop_pkg::FT_IPMC_DATA: begin
					hit = find_grp(s_d.vld, s_d.grp, fr_group_i);
					if (!snoop) begin
						dst = ~src;
					end else if (hit[4]) begin
						dst = s_d.map[hit[3:0]] & ~src;
					end else begin
						case (s_q.ctrl[snoop_pkg::CTRL_UNREG +: 2])
							snoop_pkg::UNREG_FLOOD:  dst = ~src;
							snoop_pkg::UNREG_ROUTER: dst = s_d.rmap & ~src;
							snoop_pkg::UNREG_DROP:   dst = '0;
							default:                 dst = pbit(snoop_pkg::CPU_PORT);
						endcase
					end
				end
				default: dst = ~src;
			endcase
			s_d.dec_valid = 1'b1;
			s_d.dec_trap = g_trap || g_mld;
			s_d.dec_learn = g_learn;
			if (g_trap || g_mld) begin
				s_d.dec_map = pbit(snoop_pkg::CPU_PORT);
			end else if (g_drop) begin
				s_d.dec_map = '0;
			end else begin
				s_d.dec_map = dst & fwd_ok;
			end
		end

		// register writes
		if (wr_i) begin
			case (addr_i)
				snoop_pkg::REG_CTRL:   s_d.ctrl = wdata_i;
				snoop_pkg::REG_TIMING: s_d.timing = wdata_i;
				snoop_pkg::REG_QRI:    s_d.qri = wdata_i[7:0];
				snoop_pkg::REG_PSTATE: s_d.pstate = wdata_i[8:0];
				snoop_pkg::REG_SEL:    s_d.sel = wdata_i[3:0];
				default: begin
				end
			endcase
		end

		// register reads, table is read only
		if (rd_i) begin
			case (addr_i)
				snoop_pkg::REG_CTRL:   s_d.rdata = s_q.ctrl;
				snoop_pkg::REG_TIMING: s_d.rdata = s_q.timing;
				snoop_pkg::REG_QRI:    s_d.rdata = {8'h00, s_q.qri};
				snoop_pkg::REG_PSTATE: s_d.rdata = {7'h00, s_q.pstate};
				snoop_pkg::REG_STATUS: begin
					s_d.rdata[snoop_pkg::STAT_RPORTS +: 3] = s_q.rmap;
					s_d.rdata[snoop_pkg::STAT_COUNT +: 5] = 5'($countones(s_q.vld));
					s_d.rdata[snoop_pkg::STAT_FULL] = &s_q.vld;
				end
				snoop_pkg::REG_SEL:    s_d.rdata = {12'h000, s_q.sel};
				snoop_pkg::REG_ENTRY:  s_d.rdata = {12'h000, s_q.vld[s_q.sel], s_q.map[s_q.sel]};
				snoop_pkg::REG_GRP_LO: s_d.rdata = s_q.grp[s_q.sel][15:0];
				snoop_pkg::REG_GRP_HI: s_d.rdata = s_q.grp[s_q.sel][31:16];
				default:               s_d.rdata = 16'h0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			s_q        <= '0;
			s_q.ctrl   <= snoop_pkg::CTRL_RST;
			s_q.timing <= snoop_pkg::TIMING_RST;
			s_q.qri    <= snoop_pkg::QRI_RST;
			s_q.pstate <= snoop_pkg::PSTATE_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// outputs straight from the state register
	assign rdata_o      = s_q.rdata;
	assign dec_valid_o  = s_q.dec_valid;
	assign dec_map_o    = s_q.dec_map;
	assign dec_learn_o  = s_q.dec_learn;
	assign dec_trap_o   = s_q.dec_trap;
	assign mt_wr_o      = s_q.mt_wr;
	assign mt_del_o     = s_q.mt_del;
	assign mt_grp_o     = s_q.mt_grp;
	assign mt_map_o     = s_q.mt_map;
	assign router_map_o = s_q.rmap;
endmodule : mcast_snoop_filter
`default_nettype wire

// file: hw/sec_tick.sv
// Purpose: one-second ageing tick from the core clock
// Assumes: CYCLES at least 2
// Notes:   tick_o is a one-cycle pulse from a flip-flop
`timescale 1ns/100ps
`default_nettype none
module sec_tick #(
	parameter int unsigned CYCLES = snoop_pkg::TICK_CYCLES
) (
	input  wire logic mclk_i,
	input  wire logic srst_i,
	output logic      tick_o
);
	localparam int unsigned CW = $clog2(CYCLES);
	typedef struct packed {
		logic [CW-1:0] cnt;
		logic          tick;
	} tick_st_t;
	tick_st_t s_q;
	tick_st_t s_d;

	// free-running divider
	always_comb begin
		s_d = s_q;
		s_d.tick = 1'b0;
		if (s_q.cnt == CW'(CYCLES - 1)) begin
			s_d.cnt  = '0;
			s_d.tick = 1'b1;
		end else begin
			s_d.cnt = s_q.cnt + 1'b1;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign tick_o = s_q.tick;
endmodule : sec_tick
`default_nettype wire

// file: hw/snoop_pkg.sv
// Purpose: shared constants for the multicast snoop and spanning-tree filter
// Assumes: 20 MHz core clock, three switch ports, port 2 faces the processor
// Notes:   register index is the word address on the plain register port
package snoop_pkg;
	// clock and ageing tick
	localparam int unsigned CLK_HZ       = 20_000_000;
	localparam int unsigned TICK_SEC     = 1;
	localparam int unsigned TICK_CYCLES  = CLK_HZ * TICK_SEC;
	localparam int unsigned GROUPS       = 16;
	localparam int unsigned PORTS        = 3;
	localparam logic [1:0]  CPU_PORT     = 2'h2;
	localparam int unsigned GRP_W        = 32;
	localparam int unsigned MT_W         = 16;
	localparam int unsigned RT_W         = 9;
	localparam logic [8:0]  ROUTER_TOUT_S = 9'h190;   // 400 seconds

	// register indices
	localparam logic [3:0] REG_CTRL   = 4'h0;
	localparam logic [3:0] REG_TIMING = 4'h1;
	localparam logic [3:0] REG_QRI    = 4'h2;
	localparam logic [3:0] REG_PSTATE = 4'h3;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam logic [3:0] REG_SEL    = 4'h5;
	localparam logic [3:0] REG_ENTRY  = 4'h6;
	localparam logic [3:0] REG_GRP_LO = 4'h7;
	localparam logic [3:0] REG_GRP_HI = 4'h8;

	// control fields
	localparam int CTRL_SNOOP    = 0;
	localparam int CTRL_FAST     = 1;
	localparam int CTRL_UNREG    = 2;
	localparam int CTRL_MLD      = 4;
	localparam int CTRL_STATIC   = 7;
	localparam int CTRL_RMAP     = 8;
	localparam int TIMING_ROB    = 0;
	localparam int TIMING_QI     = 8;
	localparam int STAT_RPORTS   = 0;
	localparam int STAT_COUNT    = 4;
	localparam int STAT_FULL     = 9;

	// reset values
	localparam logic [15:0] CTRL_RST   = 16'h0001;
	localparam logic [15:0] TIMING_RST = 16'h7D02;
	localparam logic [7:0]  QRI_RST    = 8'h0A;
	localparam logic [8:0]  PSTATE_RST = 9'h124;

	// spanning-tree port states
	localparam logic [2:0] STP_DISABLED   = 3'h0;
	localparam logic [2:0] STP_BLOCKING   = 3'h1;
	localparam logic [2:0] STP_LISTENING  = 3'h2;
	localparam logic [2:0] STP_LEARNING   = 3'h3;
	localparam logic [2:0] STP_FORWARDING = 3'h4;

	// frame classes from the port parsers
	localparam logic [2:0] FT_OTHER                   = 3'h0;
	localparam logic [2:0] FT_QUERY                   = 3'h1;
	localparam logic [2:0] FT_JOIN_REPORT_VERSION_ONE = 3'h2;
	localparam logic [2:0] FT_JOIN_REPORT_VERSION_TWO = 3'h3;
	localparam logic [2:0] FT_LEAVE                   = 3'h4;
	localparam logic [2:0] FT_BPDU                    = 3'h5;
	localparam logic [2:0] FT_IPMC_DATA               = 3'h6;
	localparam logic [2:0] FT_IPV6                    = 3'h7;

	// unregistered multicast treatment
	localparam logic [1:0] UNREG_FLOOD  = 2'h0;
	localparam logic [1:0] UNREG_ROUTER = 2'h1;
	localparam logic [1:0] UNREG_DROP   = 2'h2;
	localparam logic [1:0] UNREG_CPU    = 2'h3;

	// listener discovery match values
	localparam logic [7:0] V6_HOP_ONE = 8'h01;
	localparam logic [7:0] NH_ICMPV6  = 8'h3A;
	localparam logic [7:0] NH_HBH     = 8'h00;
	localparam logic [7:0] MLD_QUERY  = 8'h82;
	localparam logic [7:0] MLD_DONE   = 8'h84;
endpackage : snoop_pkg

// file: test/far_side_model.sv
// Purpose: processor side that takes trapped frames
// Assumes: told the spanning-tree state of source and egress ports
// Notes:   counts the trapped frames it keeps
`timescale 1ns/100ps
`default_nettype none
module far_side_model (
	input  wire logic       mclk_i,
	input  wire logic       srst_i,
	input  wire logic       dec_valid_i,
	input  wire logic       dec_trap_i,
	input  wire logic [2:0] src_state_i,
	input  wire logic [2:0] egress_state_i,
	output logic      [7:0] kept_o,
	output logic            send_ok_o
);
	// tagged bpdus only toward listening, learning or forwarding ports
	assign send_ok_o = egress_state_i >= snoop_pkg::STP_LISTENING;
	// keep trapped frames, drop those from disabled ports
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			kept_o <= 8'h00;
		end else if (dec_valid_i && dec_trap_i && src_state_i != snoop_pkg::STP_DISABLED) begin
			kept_o <= kept_o + 8'h01;
		end
	end
endmodule : far_side_model
`default_nettype wire

// file: test/snoop_properties.sv
// Purpose: port-level timing checks of the snoop filter
// Assumes: sees only the top module ports
// Notes:   bound to every instance of the filter
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module snoop_properties (
	input  wire logic        mclk_i,
	input  wire logic        srst_i,
	input  wire logic        rd_i,
	input  wire logic [15:0] rdata_o,
	input  wire logic        fr_valid_i,
	input  wire logic [1:0]  fr_port_i,
	input  wire logic [2:0]  fr_type_i,
	input  wire logic [7:0]  fr_hop_i,
	input  wire logic [7:0]  fr_icmp_i,
	input  wire logic        dec_valid_o,
	input  wire logic [2:0]  dec_map_o,
	input  wire logic        dec_trap_o,
	input  wire logic [2:0]  router_map_o
);
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (srst_i);
	// frame classes seen at the descriptor port
	sequence s_bpdu;
		fr_valid_i && fr_type_i == snoop_pkg::FT_BPDU;
	endsequence
	sequence s_v6;
		fr_valid_i && fr_type_i == snoop_pkg::FT_IPV6;
	endsequence
	sequence s_query;
		fr_valid_i && fr_type_i == snoop_pkg::FT_QUERY;
	endsequence
	// decision timing, trap steering, router and readback rules
	AST_DEC_PULSE: assert property (fr_valid_i |=> dec_valid_o)
		else $error("decision missing after frame");
	AST_DEC_QUIET: assert property (!fr_valid_i |=> !dec_valid_o)
		else $error("decision without frame");
	AST_CPU_NOT_ROUTER: assert property (router_map_o[2] == 1'b0)
		else $error("processor port marked as router");
	AST_RDATA_IDLE: assert property (!rd_i |=> rdata_o == 16'h0000)
		else $error("read data without read");
	AST_BPDU_TRAP: assert property (s_bpdu |=> dec_trap_o && dec_map_o == 3'h4)
		else $error("bpdu not sent to processor");
	AST_TRAP_CPU: assert property (dec_valid_o && dec_trap_o |-> dec_map_o == 3'h4)
		else $error("trapped frame not to processor only");
	AST_MLD_TYPE: assert property (s_v6 ##0 (fr_icmp_i < 8'h82 || fr_icmp_i > 8'h84)
		|=> !dec_trap_o)
		else $error("trap on wrong icmp type");
	AST_MLD_HOP: assert property (s_v6 ##0 (fr_hop_i != 8'h01) |=> !dec_trap_o)
		else $error("trap on wrong hop limit");
	AST_QUERY_SRC: assert property (s_query |=> dec_map_o[$past(fr_port_i)] == 1'b0)
		else $error("query sent back to source");
endmodule : snoop_properties
////////////////////////////////////////////////////////////////////////////////
bind mcast_snoop_filter snoop_properties snoop_properties_i (
	.mclk_i, .srst_i, .rd_i, .rdata_o, .fr_valid_i, .fr_port_i, .fr_type_i,
	.fr_hop_i, .fr_icmp_i, .dec_valid_o, .dec_map_o, .dec_trap_o, .router_map_o
);
`default_nettype wire

// file: test/testbench.sv
// Purpose: self-checking bench of the snoop filter
// Assumes: tick shortened to TK cycles
// Notes:   random group addresses from a fixed seed
`timescale 1ns/100ps
`default_nettype none
module testbench;
	localparam int unsigned TK = 4;
	logic        mclk_i = 1'b0;
	logic        srst_i = 1'b1;
	logic [3:0]  addr_i = 4'h0;
	logic [15:0] wdata_i = 16'h0000;
	logic        wr_i = 1'b0;
	logic        rd_i = 1'b0;
	logic        fr_valid_i = 1'b0;
	logic [1:0]  fr_port_i = 2'h0;
	logic [2:0]  fr_type_i = 3'h0;
	logic [31:0] fr_group_i = 32'h0;
	logic        fr_v6_mcast_i = 1'b0;
	logic [7:0]  fr_hop_i = 8'h00, fr_nh_i = 8'h00, fr_hbh_i = 8'h00, fr_icmp_i = 8'h00;
	logic [15:0] rdata_o;
	logic        dec_valid_o, dec_learn_o, dec_trap_o, mt_wr_o, mt_del_o;
	logic [2:0]  dec_map_o, mt_map_o, router_map_o, st = 3'h4;
	logic [31:0] mt_grp_o, v, g [16];
	logic [7:0]  kept_o, k;
	logic        send_ok;
	logic [15:0] d;
	integer      seed;
	int          i, cyc = 0, tests_run = 0, num_errors = 0;
	mcast_snoop_filter #(.TICK_CYCLES(TK)) mcast_snoop_filter_i (.mclk_i, .srst_i, .addr_i,
		.wdata_i, .wr_i, .rd_i, .rdata_o, .fr_valid_i, .fr_port_i, .fr_type_i, .fr_group_i,
		.fr_v6_mcast_i, .fr_hop_i, .fr_nh_i, .fr_hbh_i, .fr_icmp_i, .dec_valid_o, .dec_map_o,
		.dec_learn_o, .dec_trap_o, .mt_wr_o, .mt_del_o, .mt_grp_o, .mt_map_o, .router_map_o);
	far_side_model far_side_model_i (.mclk_i, .srst_i, .dec_valid_i(dec_valid_o),
		.dec_trap_i(dec_trap_o), .src_state_i(st), .egress_state_i(st), .kept_o,
		.send_ok_o(send_ok));
	////////////////////////////////////////////////////////////////////////////
	// clock and hang guard
	initial forever #25 mclk_i = ~mclk_i;
	always @(posedge mclk_i) begin
		cyc++;
		if (cyc == 10000) begin
			num_errors++;
			test_done();
		end
	end
	// compare and report
	task automatic check(input logic [35:0] seen, input logic [35:0] exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic test_done();
		$display("checks %0d errors %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : test_done
	// register port cycles
	task automatic wr(input logic [3:0] a, input logic [15:0] x);
		@(posedge mclk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= x;
		@(posedge mclk_i);
		wr_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [15:0] x);
		@(posedge mclk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		#1;
		x = rdata_o;
	endtask : rd
	// one frame descriptor, back from its decision
	task automatic fr(input logic [1:0] p, input logic [2:0] t, input logic [31:0] gr,
		input logic [31:0] x = 32'h0);
		@(posedge mclk_i);
		fr_valid_i <= 1'b1;
		fr_port_i <= p;
		fr_type_i <= t;
		fr_group_i <= gr;
		fr_v6_mcast_i <= (t == snoop_pkg::FT_IPV6);
		{fr_hop_i, fr_nh_i, fr_hbh_i, fr_icmp_i} <= x;
		@(posedge mclk_i);
		fr_valid_i <= 1'b0;
		#1;
		check(dec_valid_o, 1'b1);
	endtask : fr
	// miss from port 0, router port 1: flood, routers, drop, cpu
	function automatic logic [2:0] miss_map(input int m);
		case (m)
			0: miss_map = 3'h6;
			1: miss_map = 3'h2;
			2: miss_map = 3'h0;
			default: miss_map = 3'h4;
		endcase
	endfunction : miss_map
	// listener discovery match on hop, next headers, icmp type
	function automatic logic mld_hit(input logic [31:0] x);
		mld_hit = x[31:24] == 8'h01 && x[7:0] >= 8'h82 && x[7:0] <= 8'h84
			&& (x[23:16] == 8'h3A || (x[23:16] == 8'h00 && x[15:8] == 8'h3A));
	endfunction : mld_hit
	// reset value of each readable register index
	function automatic logic [15:0] rst_val(input int a);
		case (a)
			0: rst_val = snoop_pkg::CTRL_RST;
			1: rst_val = snoop_pkg::TIMING_RST;
			2: rst_val = {8'h00, snoop_pkg::QRI_RST};
			3: rst_val = {7'h00, snoop_pkg::PSTATE_RST};
			default: rst_val = 16'h0000;
		endcase
	endfunction : rst_val
	////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		seed = 32'hDBD81AF0;
		repeat (4) @(posedge mclk_i);
		srst_i <= 1'b0;
		wr(snoop_pkg::REG_STATUS, 16'hFFFF);
		for (i = 0; i < 6; i++) begin
			rd(4'(i == 5 ? 15 : i), d);
			check(d, rst_val(i));
		end
		fr(2'h2, snoop_pkg::FT_QUERY, 0);
		check(dec_map_o, 3'h3);
		fr(2'h1, snoop_pkg::FT_QUERY, 0);
		for (i = 0; i < 16; i++) g[i] = {4'hE, 4'(i), 24'($random(seed))};
		fr(2'h0, snoop_pkg::FT_JOIN_REPORT_VERSION_ONE, g[0]);
		check(router_map_o, 3'h2);
		check({dec_map_o, mt_wr_o, mt_grp_o}, {3'h2, 1'b1, g[0]});
		fr(2'h1, snoop_pkg::FT_JOIN_REPORT_VERSION_TWO, g[0]);
		check({dec_map_o, mt_wr_o, mt_map_o}, 7'h0B);
		fr(2'h2, snoop_pkg::FT_IPMC_DATA, g[0]);
		check(dec_map_o, 3'h3);
		for (i = 0; i < 4; i++) begin
			wr(snoop_pkg::REG_CTRL, 16'(i * 4 + 1));
			fr(2'h0, snoop_pkg::FT_IPMC_DATA, 32'hEF123456);
			check(dec_map_o, miss_map(i));
		end
		wr(snoop_pkg::REG_CTRL, 16'h0001);
		for (i = 1; i < 16; i++) begin
			fr(2'h0, snoop_pkg::FT_JOIN_REPORT_VERSION_TWO, g[i]);
			check(mt_wr_o, 1'b1);
		end
		fr(2'h0, snoop_pkg::FT_JOIN_REPORT_VERSION_ONE, 32'hEF123456);
		check(mt_wr_o, 1'b0);
		fr(2'h1, snoop_pkg::FT_JOIN_REPORT_VERSION_ONE, g[1]);
		check({mt_wr_o, mt_map_o}, 4'hB);
		// host reads back entry 1 of the membership table
		wr(snoop_pkg::REG_SEL, 16'h0001);
		rd(snoop_pkg::REG_ENTRY, d);
		check(d, 16'h000B);
		rd(snoop_pkg::REG_GRP_LO, d);
		check(d, g[1][15:0]);
		rd(snoop_pkg::REG_GRP_HI, d);
		check(d, g[1][31:16]);
		rd(snoop_pkg::REG_STATUS, d);
		check(d, 16'h0302);
		fr(2'h0, snoop_pkg::FT_LEAVE, g[2]);
		check(mt_del_o, 1'b0);
		wr(snoop_pkg::REG_CTRL, 16'h0003);
		fr(2'h0, snoop_pkg::FT_LEAVE, g[2]);
		check({mt_del_o, mt_grp_o}, {1'b1, g[2]});
		fr(2'h0, snoop_pkg::FT_JOIN_REPORT_VERSION_ONE, 32'hEF123456);
		check(mt_wr_o, 1'b1);
		// every port state on port 0, others forwarding
		k = kept_o;
		for (i = 0; i < 5; i++) begin
			wr(snoop_pkg::REG_PSTATE, {7'h00, 6'h24, 3'(i)});
			st <= 3'(i);
			fr(2'h0, snoop_pkg::FT_IPMC_DATA, g[1]);
			check({dec_map_o, dec_learn_o}, {(i == 4) ? 3'h2 : 3'h0, i >= 3});
			fr(2'h0, snoop_pkg::FT_BPDU, 0);
			check({dec_trap_o, dec_map_o}, 4'hC);
			check(send_ok, i >= 2);
		end
		// last trapped frame reaches the model one edge later
		@(posedge mclk_i);
		#1;
		check(kept_o - k, 8'h04);
		wr(snoop_pkg::REG_CTRL, 16'h0011);
		for (i = 0; i < 28; i++) begin
			v = {(i % 4 == 3) ? 8'h02 : 8'h01, i[0] ? 8'h00 : 8'h3A,
				i[1] ? 8'h3A : 8'($random(seed)), 8'h80 + 8'(i % 7)};
			fr(2'(i % 2), snoop_pkg::FT_IPV6, 0, v);
			check(dec_trap_o, mld_hit(v));
		end
		// router and membership ageing on the shortened tick
		fr(2'h1, snoop_pkg::FT_QUERY, 0);
		repeat (398 * TK) @(posedge mclk_i);
		#1;
		check(router_map_o, 3'h2);
		repeat (4 * TK) @(posedge mclk_i);
		#1;
		check(router_map_o, 3'h0);
		rd(snoop_pkg::REG_STATUS, d);
		check(d, 16'h0000);
		wr(snoop_pkg::REG_CTRL, 16'h0781);
		@(posedge mclk_i);
		#1;
		check(router_map_o, 3'h3);
		test_done();
	end
endmodule : testbench
`default_nettype wire
